// ==== common/pmr_pkg.sv ====
// Purpose: shared constants and types for the power monitor result and alert registers
// Assumes: register offsets are word indices on the device's own register port
// Notes: every offset, bit position and reset value lives here

// ****************************************************************
// package
// ****************************************************************
package pmr_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [5:0] ADDR_BUS_VOLTAGE = 6'h05;
  localparam logic [5:0] ADDR_DIE_TEMP = 6'h06;
  localparam logic [5:0] ADDR_CURRENT = 6'h07;
  localparam logic [5:0] ADDR_POWER = 6'h08;
  localparam logic [5:0] ADDR_ENERGY = 6'h09;
  localparam logic [5:0] ADDR_CHARGE = 6'h0a;
  localparam logic [5:0] ADDR_FLAGS = 6'h0b;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int BIT_LATCH = 15;
  localparam int BIT_READY_ALERT = 14;
  localparam int BIT_AVG_COMPARE = 13;
  localparam int BIT_LEVEL_INVERT = 12;
  localparam int BIT_ENERGY_OVF = 11;
  localparam int BIT_CHARGE_OVF = 10;
  localparam int BIT_ARITH_OVF = 9;
  localparam int BIT_RESERVED = 8;
  localparam int BIT_LIMIT_LO = 2;
  localparam int BIT_LIMIT_HI = 7;
  localparam int BIT_CONV_DONE = 1;
  localparam int BIT_MEM_OK = 0;
  localparam logic [15:0] FLAGS_RESET = 16'h0001;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
  localparam int TEMP_LSB_POS = 4;
  localparam int POWER_LIMIT_SHIFT = 8;

  // limit flag order inside the six-bit limit field, bit 2 upward
  localparam int LIM_POWER = 0;
  localparam int LIM_BUS_UNDER = 1;
  localparam int LIM_BUS_OVER = 2;
  localparam int LIM_CUR_UNDER = 3;
  localparam int LIM_CUR_OVER = 4;
  localparam int LIM_TEMP = 5;
  localparam int NUM_LIM = 6;

  // ****************************************************************
  // averaging channels
  // ****************************************************************
  localparam int NUM_CH = 4;
  localparam int CH_BUS_VOLTAGE_RESULT = 0;
  localparam int CH_CURR = 1;
  localparam int CH_TEMP = 2;
  localparam int CH_PWR = 3;
  localparam int SMP_W = 25;
  localparam int SUM_W = 36;
  localparam int CNT_W = 11;

  typedef logic [SMP_W-1:0] pmr_sample_type;
  typedef pmr_sample_type [NUM_CH-1:0] pmr_chan_type;

  // averaging count select to shift: 1,4,16,64,128,256,512,1024 samples
  function automatic logic [3:0] pmr_avg_shift(input logic [2:0] sel);
    logic [3:0] sh;
    sh = 4'h0;
    case (sel)
      3'h0: sh = 4'h0;
      3'h1: sh = 4'h2;
      3'h2: sh = 4'h4;
      3'h3: sh = 4'h6;
      3'h4: sh = 4'h7;
      3'h5: sh = 4'h8;
      3'h6: sh = 4'h9;
      default: sh = 4'ha;
    endcase
    return sh;
  endfunction

endpackage

// ==== common/pmr_avg_if.sv ====
// Purpose: carries raw samples to the averager and averaged results back
// Assumes: one clock domain
// Notes: avg_done is high for one cycle per finished sequence

`timescale 1ns/1ps
interface pmr_avg_if import pmr_pkg::*; ();
  logic smp_valid;
  pmr_chan_type smp;
  logic [2:0] avg_sel;
  logic avg_done;
  pmr_chan_type avg;

  modport src (output smp_valid, output smp, output avg_sel, input avg_done, input avg);
  modport mean (input smp_valid, input smp, input avg_sel, output avg_done, output avg);
endinterface

// ==== rtl/pmr_averager.sv ====
// Purpose: sums raw samples per channel and emits the average after the selected count
// Assumes: samples arrive as signed 25-bit values, one set per smp_valid pulse
// Notes: a change of the count select mid-sequence takes effect at the next compare of the count

`timescale 1ns/1ps
module pmr_averager import pmr_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  pmr_avg_if.mean bus
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [NUM_CH-1:0][SUM_W-1:0] sum;
    logic done;
    pmr_chan_type avg;
  } pmr_avg_state_type;

  pmr_avg_state_type st_r;
  pmr_avg_state_type st_nxt;
  logic [3:0] shift;
  logic [CNT_W-1:0] target;
  logic [NUM_CH-1:0][SUM_W-1:0] sum_add;
  pmr_chan_type mean_val;

  assign shift = pmr_avg_shift(bus.avg_sel);
  assign target = CNT_W'(11'h001 << shift);

  // ****************************************************************
  // per-channel sum and scaled result
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic signed [SUM_W-1:0] s;
      assign sum_add[g] = st_r.sum[g] + {{(SUM_W-SMP_W){bus.smp[g][SMP_W-1]}}, bus.smp[g]};
      assign s = sum_add[g];
      assign mean_val[g] = SMP_W'(s >>> shift);
    end
  endgenerate

  // ****************************************************************
  // sequence
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (bus.smp_valid) begin
      if (st_r.cnt + 11'h001 >= target) begin
        // results only leave after the whole sequence
        st_nxt.avg = mean_val;
        st_nxt.done = 1'b1;
        st_nxt.cnt = '0;
        st_nxt.sum = '0;
      end else begin
        st_nxt.cnt = st_r.cnt + 11'h001;
        st_nxt.sum = sum_add;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.avg_done = st_r.done;
  assign bus.avg = st_r.avg;

endmodule

// ==== rtl/pmr_result_regs.sv ====
// Purpose: result registers, accumulators, diagnostic flags and alert pin of a power monitor
// Assumes: converter, thresholds and register port all run on clk_sys
// Notes: register reads are one-cycle strobes; read data follows one cycle later

`timescale 1ns/1ps
module pmr_result_regs import pmr_pkg::*; #(
  parameter logic MEM_OK = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic smp_valid,
  input wire logic [15:0] smp_bus_voltage,
  input wire logic [11:0] smp_die_temp,
  input wire logic [15:0] smp_current,
  input wire logic [23:0] smp_power,
  input wire logic conv_start,
  input wire logic math_overflow,
  input wire logic [2:0] averaging_count_select,
  input wire logic accumulator_clear,
  input wire logic [11:0] thr_temp_over,
  input wire logic [15:0] thr_current_over,
  input wire logic [15:0] thr_current_under,
  input wire logic [14:0] thr_bus_over,
  input wire logic [14:0] thr_bus_under,
  input wire logic [15:0] thr_power_over,
  input wire logic [5:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [39:0] reg_rdata,
  output logic reg_rvalid,
  output logic alert_o,
  output logic alert_oe
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [15:0] bus_voltage_result;
    logic [11:0] die_temperature_result;
    logic [15:0] current_result;
    logic [23:0] power_result;
    logic [39:0] energy_accumulator;
    logic [39:0] charge_accumulator;
    logic alert_latch_enable;
    logic ready_alert_enable;
    logic averaged_compare_select;
    logic alert_level_invert;
    logic energy_overflow_flag;
    logic charge_overflow_flag;
    logic arith_overflow_flag;
    logic [NUM_LIM-1:0] limit_flags;
    logic conversion_done_flag;
    logic [39:0] rdata;
    logic rvalid;
    logic alert_oe;
    logic alert_o;
  } pmr_state_type;

  pmr_state_type st_r;
  pmr_state_type st_nxt;

  // ****************************************************************
  // averager
  // ****************************************************************
  pmr_avg_if avg_bus ();

  assign avg_bus.smp_valid = smp_valid;
  assign avg_bus.avg_sel = averaging_count_select;
  assign avg_bus.smp[CH_BUS_VOLTAGE_RESULT] = SMP_W'(signed'(smp_bus_voltage));
  assign avg_bus.smp[CH_CURR] = SMP_W'(signed'(smp_current));
  assign avg_bus.smp[CH_TEMP] = SMP_W'(signed'(smp_die_temp));
  assign avg_bus.smp[CH_PWR] = {1'b0, smp_power};

  pmr_averager u_avg (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .bus(avg_bus)
  );

  // ****************************************************************
  // compare source
  // ****************************************************************
  logic cmp_event;
  logic [15:0] cmp_bus_voltage_result;
  logic [11:0] cmp_temp;
  logic [15:0] cmp_cur;
  logic [23:0] cmp_pwr;
  logic [NUM_LIM-1:0] fault;

  always_comb begin
    if (st_r.averaged_compare_select) begin
      // slower alerts, but no trips on single noisy samples
      cmp_event = avg_bus.avg_done;
      cmp_bus_voltage_result = avg_bus.avg[CH_BUS_VOLTAGE_RESULT][15:0];
      cmp_temp = avg_bus.avg[CH_TEMP][11:0];
      cmp_cur = avg_bus.avg[CH_CURR][15:0];
      cmp_pwr = avg_bus.avg[CH_PWR][23:0];
    end else begin
      cmp_event = smp_valid;
      cmp_bus_voltage_result = smp_bus_voltage;
      cmp_temp = smp_die_temp;
      cmp_cur = smp_current;
      cmp_pwr = smp_power;
    end
  end

  always_comb begin
    fault = '0;
    fault[LIM_TEMP] = signed'(cmp_temp) > signed'(thr_temp_over);
    fault[LIM_CUR_OVER] = signed'(cmp_cur) > signed'(thr_current_over);
    fault[LIM_CUR_UNDER] = signed'(cmp_cur) < signed'(thr_current_under);
    fault[LIM_BUS_OVER] = cmp_bus_voltage_result[14:0] > thr_bus_over;
    fault[LIM_BUS_UNDER] = cmp_bus_voltage_result[14:0] < thr_bus_under;
    // limit step is 256 power steps
    fault[LIM_POWER] = cmp_pwr[23:POWER_LIMIT_SHIFT] > thr_power_over;
  end

  // ****************************************************************
  // accumulator arithmetic
  // ****************************************************************
  logic [40:0] energy_sum;
  logic [39:0] charge_sum;
  logic [39:0] charge_inc;
  logic charge_wrap;

  assign energy_sum = {1'b0, st_r.energy_accumulator} + {17'h0_0000, avg_bus.avg[CH_PWR][23:0]};
  assign charge_inc = {{24{avg_bus.avg[CH_CURR][15]}}, avg_bus.avg[CH_CURR][15:0]};
  assign charge_sum = st_r.charge_accumulator + charge_inc;
  // signed overflow: equal operand signs, result sign differs
  assign charge_wrap = (st_r.charge_accumulator[39] == charge_inc[39]) &&
                       (charge_sum[39] != charge_inc[39]);

  // ****************************************************************
  // register access decode
  // ****************************************************************
  logic flags_read;
  logic flags_write;
  logic [15:0] flags_word;

  assign flags_read = reg_rd && (reg_addr == ADDR_FLAGS);
  assign flags_write = reg_wr && (reg_addr == ADDR_FLAGS);

  always_comb begin
    flags_word = FLAGS_RESET;
    flags_word[BIT_LATCH] = st_r.alert_latch_enable;
    flags_word[BIT_READY_ALERT] = st_r.ready_alert_enable;
    flags_word[BIT_AVG_COMPARE] = st_r.averaged_compare_select;
    flags_word[BIT_LEVEL_INVERT] = st_r.alert_level_invert;
    flags_word[BIT_ENERGY_OVF] = st_r.energy_overflow_flag;
    flags_word[BIT_CHARGE_OVF] = st_r.charge_overflow_flag;
    flags_word[BIT_ARITH_OVF] = st_r.arith_overflow_flag;
    flags_word[BIT_RESERVED] = 1'b0;
    flags_word[BIT_LIMIT_HI:BIT_LIMIT_LO] = st_r.limit_flags;
    flags_word[BIT_CONV_DONE] = st_r.conversion_done_flag;
    flags_word[BIT_MEM_OK] = MEM_OK;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  logic alert_active;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;

    // results move only on a finished averaging sequence
    if (avg_bus.avg_done) begin
      st_nxt.bus_voltage_result = avg_bus.avg[CH_BUS_VOLTAGE_RESULT][15:0];
      st_nxt.die_temperature_result = avg_bus.avg[CH_TEMP][11:0];
      st_nxt.current_result = avg_bus.avg[CH_CURR][15:0];
      st_nxt.power_result = avg_bus.avg[CH_PWR][23:0];
      st_nxt.energy_accumulator = energy_sum[39:0];
      st_nxt.charge_accumulator = charge_sum;
    end

    // write side: only the four control bits are writable
    if (flags_write) begin
      st_nxt.alert_latch_enable = reg_wdata[BIT_LATCH];
      st_nxt.ready_alert_enable = reg_wdata[BIT_READY_ALERT];
      st_nxt.averaged_compare_select = reg_wdata[BIT_AVG_COMPARE];
      st_nxt.alert_level_invert = reg_wdata[BIT_LEVEL_INVERT];
    end

    // overflow flags: a clear in the same cycle as a new overflow loses
    if (accumulator_clear) begin
      st_nxt.energy_accumulator = ACC_RESET;
      st_nxt.charge_accumulator = ACC_RESET;
      st_nxt.energy_overflow_flag = 1'b0;
      st_nxt.charge_overflow_flag = 1'b0;
    end
    if (accumulator_clear || conv_start) begin
      st_nxt.arith_overflow_flag = 1'b0;
    end
    if (avg_bus.avg_done && energy_sum[40]) begin
      st_nxt.energy_overflow_flag = 1'b1;
    end
    if (avg_bus.avg_done && charge_wrap) begin
      st_nxt.charge_overflow_flag = 1'b1;
    end
    if (math_overflow) begin
      st_nxt.arith_overflow_flag = 1'b1;
    end

    // limit flags
    if (st_r.alert_latch_enable) begin
      if (flags_read) begin
        st_nxt.limit_flags = '0;
      end
      if (cmp_event) begin
        st_nxt.limit_flags = st_nxt.limit_flags | fault;
      end
    end else if (cmp_event) begin
      st_nxt.limit_flags = fault;
    end

    // conversion done
    if (flags_read || conv_start) begin
      st_nxt.conversion_done_flag = 1'b0;
    end
    if (avg_bus.avg_done) begin
      st_nxt.conversion_done_flag = 1'b1;
    end

    // read data, unmapped offsets read zero
    if (reg_rd) begin
      st_nxt.rvalid = 1'b1;
      if (reg_addr == ADDR_BUS_VOLTAGE) begin
        st_nxt.rdata = {24'h00_0000, st_r.bus_voltage_result};
      end else if (reg_addr == ADDR_DIE_TEMP) begin
        st_nxt.rdata = {24'h00_0000, st_r.die_temperature_result, 4'h0};
      end else if (reg_addr == ADDR_CURRENT) begin
        st_nxt.rdata = {24'h00_0000, st_r.current_result};
      end else if (reg_addr == ADDR_POWER) begin
        st_nxt.rdata = {16'h0000, st_r.power_result};
      end else if (reg_addr == ADDR_ENERGY) begin
        st_nxt.rdata = st_r.energy_accumulator;
      end else if (reg_addr == ADDR_CHARGE) begin
        st_nxt.rdata = st_r.charge_accumulator;
      end else if (reg_addr == ADDR_FLAGS) begin
        st_nxt.rdata = {24'h00_0000, flags_word};
      end else begin
        st_nxt.rdata = ACC_RESET;
      end
    end

    // alert from the new flag values, so it moves with the flags
    alert_active = (|st_nxt.limit_flags) ||
                   (st_nxt.conversion_done_flag && st_nxt.ready_alert_enable);
    // open-drain: pull low when active under normal polarity, or when idle under inverted polarity
    st_nxt.alert_oe = alert_active ^ st_nxt.alert_level_invert;
    st_nxt.alert_o = 1'b0;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // pin only ever pulls low, so its level flop never leaves zero
  assign alert_o = st_r.alert_o;
  assign alert_oe = st_r.alert_oe;
  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;

endmodule

// ==== sim/pmr_result_regs_assertions.sv ====
// Purpose: port-level checks of the result and alert register block
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every instance of the block's top module

`timescale 1ns/1ps
module pmr_chk import pmr_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic smp_valid,
  input wire logic conv_start,
  input wire logic math_overflow,
  input wire logic accumulator_clear,
  input wire logic [5:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [39:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic alert_o,
  input wire logic alert_oe
);
  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  chk_valid_cause: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read valid without a read");
  chk_bus_positive: assert property (reg_rd && reg_addr == ADDR_BUS_VOLTAGE
    |=> reg_rdata[39:15] == '0) else $error("bus voltage negative or wide");
  chk_temp_low_zero: assert property (reg_rd && reg_addr == ADDR_DIE_TEMP
    |=> reg_rdata[3:0] == 4'h0 && reg_rdata[39:16] == '0) else $error("temperature low bits");
  chk_current_width: assert property (reg_rd && reg_addr == ADDR_CURRENT
    |=> reg_rdata[39:16] == '0) else $error("current wider than 16 bits");
  chk_power_width: assert property (reg_rd && reg_addr == ADDR_POWER
    |=> reg_rdata[39:24] == '0) else $error("power wider than 24 bits");
  chk_flags_reserved: assert property (reg_rd && reg_addr == ADDR_FLAGS
    |=> !reg_rdata[BIT_RESERVED] && reg_rdata[39:16] == '0) else $error("reserved flag bit set");
  chk_unmapped_zero: assert property (reg_rd && (reg_addr < ADDR_BUS_VOLTAGE ||
    reg_addr > ADDR_FLAGS) |=> reg_rdata == '0) else $error("unmapped read not zero");
  chk_pin_open_drain: assert property (alert_o == 1'b0)
    else $error("alert pin driven high");
  // alert may only move in reaction to a sample, a register access or a control pulse
  chk_alert_quiet: assert property (!(smp_valid || reg_rd || reg_wr || conv_start ||
    accumulator_clear || math_overflow) [*4] |=> $stable(alert_oe)) else $error("alert moved");

  cov_flag_read: cover property (reg_rd && reg_addr == ADDR_FLAGS);
  cov_alert_rise: cover property ($rose(alert_oe));
  cov_back_samples: cover property (smp_valid ##1 smp_valid);
endmodule

bind pmr_result_regs pmr_chk u_chk (.clk_sys, .rst_b, .smp_valid, .conv_start, .math_overflow,
  .accumulator_clear, .reg_addr, .reg_rd, .reg_wr, .reg_rdata, .reg_rvalid, .alert_o, .alert_oe);

// ==== sim/pmr_host_model.sv ====
// Purpose: register host that reads and writes the block's register port
// Assumes: one-cycle strobes, read data valid the cycle after the strobe
// Notes: returns unknown data when no read valid came back

`timescale 1ns/1ps
module pmr_host_model (
  input wire logic clk_sys,
  output logic [5:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  input wire logic [39:0] reg_rdata,
  input wire logic reg_rvalid
);
  // ****************************************************************
  // access tasks
  // ****************************************************************
  initial begin
    reg_addr = 6'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    // stale data scrambled so a late capture cannot pass by luck
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [5:0] a, output logic [39:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 'x;
  endtask
endmodule

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for the result and alert registers
// Assumes: raw mode limit flags at c1, results two edges after the last sample
// Notes: overflow of the charge accumulator is too long to reach here

`timescale 1ns/1ps
module tb_top import pmr_pkg::*; ;
  logic clk_sys, rst_b, smp_valid, conv_start, math_overflow, accumulator_clear;
  logic [15:0] smp_bus_voltage, smp_current, thr_current_over, thr_current_under;
  logic [15:0] thr_power_over, reg_wdata;
  logic [11:0] smp_die_temp, thr_temp_over;
  logic [23:0] smp_power;
  logic [14:0] thr_bus_over, thr_bus_under;
  logic [2:0] averaging_count_select;
  logic [5:0] reg_addr;
  logic reg_rd, reg_wr, reg_rvalid, alert_o, alert_oe;
  logic [39:0] reg_rdata, d;
  int n_mismatch = 0;
  int checks = 0;

  // ****************************************************************
  // harness
  // ****************************************************************
  pmr_result_regs u_dut (.clk_sys, .rst_b, .smp_valid, .smp_bus_voltage, .smp_die_temp,
    .smp_current, .smp_power, .conv_start, .math_overflow, .averaging_count_select,
    .accumulator_clear, .thr_temp_over, .thr_current_over, .thr_current_under, .thr_bus_over,
    .thr_bus_under, .thr_power_over, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .alert_o, .alert_oe);
  pmr_host_model u_host (.clk_sys, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
    .reg_rvalid);

  always #12.5 clk_sys = ~clk_sys;

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic rdc(input logic [5:0] a, input logic [39:0] exp, input string nm);
    u_host.rd(a, d);
    chk(nm, exp, d);
  endtask

  task automatic pin(input logic exp);
    chk("alert_oe", 40'(exp), 40'(alert_oe));
  endtask

  task automatic smp(input logic [15:0] v, input logic [15:0] c);
    @(posedge clk_sys);
    #1;
    smp_bus_voltage = v;
    smp_current = c;
    smp_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    smp_valid = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // k: 0 new conversion, 1 accumulator clear, 2 arithmetic overflow
  task automatic pulse(input int k);
    @(posedge clk_sys);
    #1;
    conv_start = (k == 0);
    accumulator_clear = (k == 1);
    math_overflow = (k == 2);
    @(posedge clk_sys);
    #1;
    {conv_start, accumulator_clear, math_overflow} = 3'h0;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic thr_def();
    thr_temp_over = 12'h7ff;
    thr_current_over = 16'h7fff;
    thr_current_under = 16'h8000;
    thr_bus_over = 15'h7fff;
    thr_bus_under = 15'h0000;
    thr_power_over = 16'hffff;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    {clk_sys, rst_b, smp_valid, conv_start, math_overflow, accumulator_clear} = 6'h00;
    averaging_count_select = 3'h0;
    smp_die_temp = 12'hfd0;
    smp_power = 24'h12_3456;
    smp_bus_voltage = 16'h0000;
    smp_current = 16'h0000;
    thr_def();
    repeat (3) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    for (int a = 5; a <= 11; a++) rdc(6'(a), a == 11 ? FLAGS_RESET : RESULT_RESET, "reset");
    rdc(6'h00, 16'h0000, "unmapped");
    u_host.wr(ADDR_BUS_VOLTAGE, 16'hffff);
    rdc(ADDR_BUS_VOLTAGE, 16'h0000, "ro bus_voltage_result");
    u_host.wr(ADDR_FLAGS, 16'hffff);
    rdc(ADDR_FLAGS, 16'hf001, "ctl bits");
    u_host.wr(ADDR_FLAGS, 16'h0000);
    smp(16'h1234, 16'h8001);
    rdc(ADDR_BUS_VOLTAGE, 16'h1234, "bus_voltage_result");
    rdc(ADDR_DIE_TEMP, 16'hfd00, "temp");
    rdc(ADDR_CURRENT, 16'h8001, "current");
    rdc(ADDR_POWER, 24'h12_3456, "power");
    rdc(ADDR_ENERGY, 24'h12_3456, "energy");
    rdc(ADDR_CHARGE, 40'hff_ffff_8001, "charge");
    pin(1'b0);
    rdc(ADDR_FLAGS, 16'h0003, "done");
    rdc(ADDR_FLAGS, 16'h0001, "done read");
    // equal values must not trip: every compare is strict
    smp_die_temp = 12'h100;
    smp_bus_voltage = 16'h1234;
    {thr_power_over, thr_current_over, thr_current_under} = {16'h1234, 16'h0100, 16'h0100};
    {thr_bus_over, thr_bus_under, thr_temp_over} = {15'h1234, 15'h1234, 12'h100};
    smp(16'h1234, 16'h0100);
    rdc(ADDR_FLAGS, 16'h0003, "equal limits");
    for (int k = 0; k < NUM_LIM; k++) begin
      thr_def();
      case (k)
        LIM_POWER: thr_power_over = 16'h1233;
        LIM_BUS_UNDER: thr_bus_under = 15'h1235;
        LIM_BUS_OVER: thr_bus_over = 15'h1233;
        LIM_CUR_UNDER: thr_current_under = 16'h0101;
        LIM_CUR_OVER: thr_current_over = 16'h00ff;
        default: thr_temp_over = 12'h0ff;
      endcase
      smp(16'h1234, 16'h0100);
      pin(1'b1);
      rdc(ADDR_FLAGS, 16'h0003 | (16'h0004 << k), "limit");
      thr_def();
      smp(16'h1234, 16'h0100);
      pin(1'b0);
      rdc(ADDR_FLAGS, 16'h0003, "limit gone");
    end
    pulse(1);
    rdc(ADDR_ENERGY, 16'h0000, "energy clr");
    rdc(ADDR_CHARGE, 16'h0000, "charge clr");
    u_host.wr(ADDR_FLAGS, 16'h8000);
    thr_bus_over = 15'h1233;
    smp(16'h1234, 16'h0100);
    thr_def();
    smp(16'h1234, 16'h0100);
    pin(1'b1);
    rdc(ADDR_FLAGS, 16'h8013, "latched");
    pin(1'b0);
    rdc(ADDR_FLAGS, 16'h8001, "latch read");
    u_host.wr(ADDR_FLAGS, 16'h4000);
    pin(1'b0);
    smp(16'h1234, 16'h0100);
    pin(1'b1);
    pulse(0);
    pin(1'b0);
    rdc(ADDR_FLAGS, 16'h4001, "conv start");
    u_host.wr(ADDR_FLAGS, 16'h1000);
    pin(1'b1);
    thr_bus_over = 15'h1233;
    smp(16'h1234, 16'h0100);
    pin(1'b0);
    thr_def();
    smp(16'h1234, 16'h0100);
    pin(1'b1);
    pulse(2);
    rdc(ADDR_FLAGS, 16'h1203, "math ovf");
    pulse(0);
    pulse(2);
    pulse(1);
    rdc(ADDR_FLAGS, 16'h1001, "math clr");
    // raw samples reach 0x40 but their mean of 0x28 stays under the limit
    u_host.wr(ADDR_FLAGS, 16'h2000);
    averaging_count_select = 3'h1;
    thr_bus_over = 15'h0030;
    for (int i = 1; i <= 4; i++) begin
      smp(16'(i * 16), 16'h0100);
      if (i == 3)
        rdc(ADDR_BUS_VOLTAGE, 16'h1234, "avg pending");
    end
    rdc(ADDR_BUS_VOLTAGE, 16'h0028, "avg bus_voltage_result");
    rdc(ADDR_FLAGS, 16'h2003, "avg compare");
    // longer counts: steady samples one short of the count must not update
    for (int s = 2; s < 8; s++) begin
      averaging_count_select = 3'(s);
      @(posedge clk_sys);
      #1;
      smp_bus_voltage = 16'h0100 + 16'(s);
      smp_valid = 1'b1;
      repeat ((s < 4 ? 1 << (2 * s) : 1 << (s + 3)) - 1) @(posedge clk_sys);
      #1;
      smp_valid = 1'b0;
      rdc(ADDR_BUS_VOLTAGE, s == 2 ? 16'h0028 : 16'h00ff + 16'(s), "avg hold");
      smp(16'h0100 + 16'(s), 16'h0100);
      rdc(ADDR_BUS_VOLTAGE, 16'h0100 + 16'(s), "avg count");
    end
    averaging_count_select = 3'h0;
    thr_def();
    u_host.wr(ADDR_FLAGS, 16'h0000);
    // back-to-back full-scale power until the energy sum wraps past 40 bits
    @(posedge clk_sys);
    #1;
    smp_power = 24'hff_ffff;
    smp_valid = 1'b1;
    repeat (65540) @(posedge clk_sys);
    #1;
    smp_valid = 1'b0;
    repeat (3) @(posedge clk_sys);
    rdc(ADDR_FLAGS, 16'h0803, "energy ovf");
    rdc(ADDR_FLAGS, 16'h0801, "ovf sticky");
    pulse(1);
    rdc(ADDR_FLAGS, 16'h0001, "ovf clr");
    summarize();
  end

  initial begin
    #2_300_000;
    n_mismatch++;
    summarize();
  end
endmodule
